// ===== fgw_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the frame gated watchdog and idle control block.
 * Assumes the includer also imports fgw_pkg for the types.
 */
`ifndef FGW_REGS_SVH
`define FGW_REGS_SVH

// register addresses: power control on the sfr bus, watchdog in xdata
`define FGW_PWR_CTRL_ADDR 8'h87
`define FGW_WD_CTRL_ADDR 16'hFF93

// watchdog control and status fields
`define FGW_WD_REFRESH_BIT 0
`define FGW_WD_CAUSE_BIT 6
`define FGW_WD_ENABLE_BIT 7

// power control fields
`define FGW_PC_IDLE_BIT 0
`define FGW_PC_FLAGS_LO 2
`define FGW_PC_FLAGS_HI 3
`define FGW_PC_BAUD_BIT 7

// reset values
`define FGW_WD_ENABLE_RST 1'b0
`define FGW_WD_CAUSE_RST 1'b0
`define FGW_PC_IDLE_RST 1'b0
`define FGW_PC_FLAGS_RST 2'h0
`define FGW_PC_BAUD_RST 1'b0
`define FGW_WD_COUNT_RST 5'h00

// watchdog counter
`define FGW_WD_COUNT_W 5
`define FGW_WD_COUNT_LAST 5'h1F

// timing
`define FGW_CLK_HZ 25000000
`define FGW_TICK_MS 1
`define FGW_TICK_CYC ((`FGW_CLK_HZ / 1000) * `FGW_TICK_MS)
`define FGW_EXTERNAL_INTERRUPT_ONE_MIN_US 400
`define FGW_EXTERNAL_INTERRUPT_ONE_CYC ((`FGW_EXTERNAL_INTERRUPT_ONE_MIN_US * (`FGW_CLK_HZ / 1000) + 999) / 1000)

`endif

// ===== fgw_pkg.sv
/*
 * Types shared by the frame gated watchdog modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fgw_pkg;

	// gray coded along off -> armed -> run -> suspended
	typedef enum logic [1:0] {
		FGW_WD_OFF = 2'h0,
		FGW_WD_ARMED = 2'h1,
		FGW_WD_RUN = 2'h3,
		FGW_WD_SUSP = 2'h2
	} fgw_wd_state_t;

endpackage

// ===== fgw_tick_if.sv
/*
 * Carrier between the watchdog core and its millisecond tick divider.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface fgw_tick_if;
	logic run;
	logic tick;

	modport core (output run, input tick);
	modport gen (input run, output tick);
endinterface

// ===== fgw_tick_gen.sv
/*
 * Millisecond tick divider: one-cycle enable pulse every TICK_CYCLES.
 * Assumes the core holds run low to restart the phase.
 */
`timescale 1ns/1ps

module fgw_tick_gen
	import fgw_pkg::*;
#(
	parameter int TICK_CYCLES = 25000
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	fgw_tick_if.gen tk
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] div_q;
	logic tick_q;

	// restart on run low so a refresh always buys a full period
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_q <= '0;
		end else if (!tk.run || div_q == LAST) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tk.run && div_q == LAST;
		end
	end

	assign tk.tick = tick_q;
endmodule

// ===== fgw_watchdog_idle.sv
/*
 * Frame gated watchdog with idle mode control for the embedded core.
 * Holds the watchdog control/status register (xdata) and the power
 * control register (sfr), the start-of-frame gate, the external_interrupt_one wake filter
 * and the watchdog reset pulse.
 * Assumes sfr and xdata strobes, start-of-frame and usb reset come from
 * logic on i_clk_sys; only the external_interrupt_one pin is asynchronous.
 */
`timescale 1ns/1ps
`include "fgw_regs.svh"

// Behaviour
// - watchdog advances on a 1 ms tick divided from the system clock
// - watchdog counter is five bits, stepped by the 1 ms tick
// - no counting before a start-of-frame is seen, even when enabled
// - 32 ms without refresh while running resets the core
// - writing one to refresh bit 0 restarts; zero ignored; reads zero
// - idle suspends counting; external_interrupt_one wake clears idle and resumes counting
// - enable bit 7 cleared only by power-up or enabled usb reset
// - writing one to enable starts the watchdog; zero keeps it disabled
// - cause bit 6 set by timeout, clear on power-up/usb reset or write one
// - software sets idle bit 0; only external_interrupt_one logic or an enabled usb reset clears it
// - external_interrupt_one must stay asserted 400 us before recognition and wake
// - idle puts core idle, RAM low power, watchdog suspended
// - power control bits 3..2 are read/write general flags, reset 00
// - power control bit 7 selects double baud rate, reset zero
// - power control register sits at sfr address 87h
module fgw_watchdog_idle
	import fgw_pkg::*;
#(
	parameter int TICK_CYCLES = `FGW_TICK_CYC,
	parameter int EXTERNAL_INTERRUPT_ONE_CYCLES = `FGW_EXTERNAL_INTERRUPT_ONE_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	input wire logic [15:0] i_xd_addr,
	input wire logic i_xd_wr,
	input wire logic i_xd_rd,
	input wire logic [7:0] i_xd_wdata,
	output logic [7:0] o_xd_rdata,
	output logic o_xd_hit,
	input wire logic i_sof_det,
	input wire logic i_usb_rst,
	input wire logic i_usb_rst_en,
	input wire logic i_ext_external_interrupt_one_n,
	output logic o_mcu_wdt_reset,
	output logic o_mcu_idle,
	output logic o_ram_low_power,
	output logic o_external_interrupt_one_irq,
	output logic o_baud_double,
	output logic o_wdt_running
);
	localparam int IW = $clog2(EXTERNAL_INTERRUPT_ONE_CYCLES + 1);
	localparam logic [IW-1:0] EXTERNAL_INTERRUPT_ONE_LAST = IW'(EXTERNAL_INTERRUPT_ONE_CYCLES - 1);
	localparam logic [IW-1:0] EXTERNAL_INTERRUPT_ONE_DONE = IW'(EXTERNAL_INTERRUPT_ONE_CYCLES);

	fgw_tick_if tk ();

	fgw_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.tk(tk)
	);

	fgw_wd_state_t state_q;
	fgw_wd_state_t state_d;
	logic [`FGW_WD_COUNT_W-1:0] count_q;
	logic wd_enable_q;
	logic wd_cause_q;
	logic sof_seen_q;
	logic idle_q;
	logic [1:0] gen_flags_q;
	logic baud_double_q;
	logic wdt_reset_q;
	logic external_interrupt_one_irq_q;
	logic external_interrupt_one_meta_q;
	logic external_interrupt_one_sync_q;
	logic [IW-1:0] external_interrupt_one_cnt_q;
	logic [7:0] sfr_rdata_q;
	logic [7:0] xd_rdata_q;

	logic pwr_sel;
	logic wd_sel;
	logic pwr_wr;
	logic wd_wr;
	logic refresh;
	logic func_rst;
	logic external_interrupt_one_active;
	logic external_interrupt_one_wake;
	logic counting;
	logic timeout;
	logic [7:0] wd_status;
	logic [7:0] pwr_word;

	// address decoding
	always_comb begin
		if (i_sfr_addr == `FGW_PWR_CTRL_ADDR) begin
			pwr_sel = 1'b1;
		end else begin
			pwr_sel = 1'b0;
		end
	end

	always_comb begin
		if (i_xd_addr == `FGW_WD_CTRL_ADDR) begin
			wd_sel = 1'b1;
		end else begin
			wd_sel = 1'b0;
		end
	end

	assign pwr_wr = pwr_sel && i_sfr_wr;
	assign wd_wr = wd_sel && i_xd_wr;
	// only a one restarts the count; a zero write is a plain no-op
	assign refresh = wd_wr && i_xd_wdata[`FGW_WD_REFRESH_BIT];
	// usb reset acts only when that reset source is enabled
	assign func_rst = i_usb_rst && i_usb_rst_en;

	// external_interrupt_one pin synchroniser; pin is active low
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			external_interrupt_one_meta_q <= 1'b1;
			external_interrupt_one_sync_q <= 1'b1;
		end else begin
			external_interrupt_one_meta_q <= i_ext_external_interrupt_one_n;
			external_interrupt_one_sync_q <= external_interrupt_one_meta_q;
		end
	end

	assign external_interrupt_one_active = !external_interrupt_one_sync_q;

	// assertion length filter; saturates so one long pulse wakes once
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			external_interrupt_one_cnt_q <= '0;
		end else if (!external_interrupt_one_active) begin
			external_interrupt_one_cnt_q <= '0;
		end else if (external_interrupt_one_cnt_q != EXTERNAL_INTERRUPT_ONE_DONE) begin
			external_interrupt_one_cnt_q <= external_interrupt_one_cnt_q + 1'b1;
		end
	end

	// fires once, in the cycle the filter reaches its length
	assign external_interrupt_one_wake = external_interrupt_one_active && external_interrupt_one_cnt_q == EXTERNAL_INTERRUPT_ONE_LAST;

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			external_interrupt_one_irq_q <= 1'b0;
		end else begin
			external_interrupt_one_irq_q <= external_interrupt_one_wake;
		end
	end

	// idle bit: software sets, only the external_interrupt_one wake or an enabled usb reset clears
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idle_q <= `FGW_PC_IDLE_RST;
		end else if (func_rst) begin
			idle_q <= `FGW_PC_IDLE_RST;
		end else if (pwr_wr && i_sfr_wdata[`FGW_PC_IDLE_BIT]) begin
			idle_q <= 1'b1;
		end else if (external_interrupt_one_wake) begin
			idle_q <= 1'b0;
		end
	end

	// general flags and baud doubling are plain storage
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gen_flags_q <= `FGW_PC_FLAGS_RST;
			baud_double_q <= `FGW_PC_BAUD_RST;
		end else if (func_rst) begin
			gen_flags_q <= `FGW_PC_FLAGS_RST;
			baud_double_q <= `FGW_PC_BAUD_RST;
		end else if (pwr_wr) begin
			gen_flags_q <= i_sfr_wdata[`FGW_PC_FLAGS_HI:`FGW_PC_FLAGS_LO];
			baud_double_q <= i_sfr_wdata[`FGW_PC_BAUD_BIT];
		end
	end

	// enable: write one sets; a zero write cannot stop a started dog
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wd_enable_q <= `FGW_WD_ENABLE_RST;
		end else if (func_rst) begin
			wd_enable_q <= `FGW_WD_ENABLE_RST;
		end else if (wd_wr && i_xd_wdata[`FGW_WD_ENABLE_BIT]) begin
			wd_enable_q <= 1'b1;
		end
	end

	// reset cause: a timeout in the clearing cycle still sets it
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wd_cause_q <= `FGW_WD_CAUSE_RST;
		end else if (func_rst) begin
			wd_cause_q <= `FGW_WD_CAUSE_RST;
		end else if (timeout) begin
			wd_cause_q <= 1'b1;
		end else if (wd_wr && i_xd_wdata[`FGW_WD_CAUSE_BIT]) begin
			wd_cause_q <= 1'b0;
		end
	end

	// start-of-frame gate, sticky until power-up or usb reset
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sof_seen_q <= 1'b0;
		end else if (func_rst) begin
			sof_seen_q <= 1'b0;
		end else if (i_sof_det) begin
			sof_seen_q <= 1'b1;
		end
	end

	// watchdog sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			FGW_WD_OFF: begin
				if (wd_enable_q) begin
					state_d = FGW_WD_ARMED;
				end
			end
			FGW_WD_ARMED: begin
				if (sof_seen_q) begin
					state_d = FGW_WD_RUN;
				end
			end
			FGW_WD_RUN: begin
				if (idle_q) begin
					state_d = FGW_WD_SUSP;
				end
			end
			FGW_WD_SUSP: begin
				if (!idle_q) begin
					state_d = FGW_WD_RUN;
				end
			end
			default: begin
				state_d = FGW_WD_OFF;
			end
		endcase
		if (!wd_enable_q) begin
			state_d = FGW_WD_OFF;
		end
	end

	// usb reset parks the sequencer; a timeout leaves it running
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= FGW_WD_OFF;
		end else if (func_rst) begin
			state_q <= FGW_WD_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// idle restarts the divider, so suspension can only lengthen the timeout
	assign counting = state_q == FGW_WD_RUN && !idle_q;
	assign tk.run = counting && !refresh;
	// a refresh in the expiry cycle still counts as in time
	assign timeout = counting && tk.tick && !refresh && count_q == `FGW_WD_COUNT_LAST;

	// count of elapsed milliseconds since the last refresh
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count_q <= `FGW_WD_COUNT_RST;
		end else if (func_rst || state_q == FGW_WD_OFF || state_q == FGW_WD_ARMED) begin
			count_q <= `FGW_WD_COUNT_RST;
		end else if (refresh || timeout) begin
			count_q <= `FGW_WD_COUNT_RST;
		end else if (counting && tk.tick) begin
			count_q <= count_q + 1'b1;
		end
	end

	// the enable and cause bits survive the reset this pulse causes
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wdt_reset_q <= 1'b0;
		end else begin
			wdt_reset_q <= timeout;
		end
	end

	// register images; refresh and reserved bits always read zero
	always_comb begin
		wd_status = 8'h00;
		wd_status[`FGW_WD_ENABLE_BIT] = wd_enable_q;
		wd_status[`FGW_WD_CAUSE_BIT] = wd_cause_q;
	end

	always_comb begin
		pwr_word = 8'h00;
		pwr_word[`FGW_PC_BAUD_BIT] = baud_double_q;
		pwr_word[`FGW_PC_FLAGS_HI:`FGW_PC_FLAGS_LO] = gen_flags_q;
		pwr_word[`FGW_PC_IDLE_BIT] = idle_q;
	end

	// read data stands one cycle, then returns to zero
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			xd_rdata_q <= 8'h00;
		end else if (wd_sel && i_xd_rd) begin
			xd_rdata_q <= wd_status;
		end else begin
			xd_rdata_q <= 8'h00;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sfr_rdata_q <= 8'h00;
		end else if (pwr_sel && i_sfr_rd) begin
			sfr_rdata_q <= pwr_word;
		end else begin
			sfr_rdata_q <= 8'h00;
		end
	end

	assign o_sfr_hit = pwr_sel && (i_sfr_rd || i_sfr_wr);
	assign o_xd_hit = wd_sel && (i_xd_rd || i_xd_wr);
	assign o_sfr_rdata = sfr_rdata_q;
	assign o_xd_rdata = xd_rdata_q;
	assign o_mcu_wdt_reset = wdt_reset_q;
	assign o_mcu_idle = idle_q;
	assign o_ram_low_power = idle_q;
	assign o_external_interrupt_one_irq = external_interrupt_one_irq_q;
	assign o_baud_double = baud_double_q;
	assign o_wdt_running = counting;
endmodule

// ===== fgw_watchdog_idle_asserts.sv
/* Assertion checker for fgw_watchdog_idle, bound to every instance.
   Assumes its parameters match the instance it watches. */
`timescale 1ns/1ps
module fgw_chk #(
	parameter int TICK_CYCLES = 4,
	parameter int EXTERNAL_INTERRUPT_ONE_CYCLES = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_sfr_hit,
	input wire logic [15:0] i_xd_addr,
	input wire logic i_xd_wr,
	input wire logic i_xd_rd,
	input wire logic [7:0] i_xd_wdata,
	input wire logic [7:0] o_xd_rdata,
	input wire logic o_xd_hit,
	input wire logic i_usb_rst,
	input wire logic i_usb_rst_en,
	input wire logic i_ext_external_interrupt_one_n,
	input wire logic o_mcu_wdt_reset,
	input wire logic o_mcu_idle,
	input wire logic o_ram_low_power,
	input wire logic o_external_interrupt_one_irq,
	input wire logic o_baud_double,
	input wire logic o_wdt_running
);
	// two cycles of slack for the divider restart after a refresh
	localparam int MIN_RUN = 32 * TICK_CYCLES - 2;
	wire logic sfr_sel = i_sfr_addr == 8'h87;
	wire logic xd_sel = i_xd_addr == 16'hFF93;
	int low_run;
	int run_cnt;
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_run <= 0;
		end else begin
			low_run <= i_ext_external_interrupt_one_n ? 0 : low_run + 1;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			run_cnt <= 0;
		end else if (o_mcu_wdt_reset || (i_usb_rst && i_usb_rst_en)) begin
			run_cnt <= 0;
		end else if (i_xd_wr && xd_sel && i_xd_wdata[0]) begin
			run_cnt <= 0;
		end else if (o_wdt_running) begin
			run_cnt <= run_cnt + 1;
		end
	end
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	sequence s_sfr_wr;
		i_sfr_wr && sfr_sel;
	endsequence
	sequence s_pin_held;
		$past(low_run, 4) >= EXTERNAL_INTERRUPT_ONE_CYCLES - 2;
	endsequence
	a_sfr_hit_decode: assert property (o_sfr_hit == (sfr_sel && (i_sfr_rd || i_sfr_wr)))
		else $error("sfr hit decode wrong");
	a_xd_hit_decode: assert property (o_xd_hit == (xd_sel && (i_xd_rd || i_xd_wr)))
		else $error("xdata hit decode wrong");
	a_sfr_read_back: assert property (i_sfr_rd && sfr_sel && !i_sfr_wr |=> (o_sfr_rdata & 8'h72) == 8'h00
		&& o_sfr_rdata[7] == $past(o_baud_double) && o_sfr_rdata[0] == $past(o_mcu_idle))
		else $error("power control read data wrong");
	a_sfr_quiet_data: assert property (!(i_sfr_rd && sfr_sel) |=> o_sfr_rdata == 8'h00)
		else $error("sfr read data without a read");
	a_refresh_reads_zero: assert property (i_xd_rd && xd_sel |=> o_xd_rdata[5:0] == 6'h00)
		else $error("refresh or reserved bits read nonzero");
	a_baud_write: assert property (s_sfr_wr |=> o_baud_double == $past(i_sfr_wdata[7]))
		else $error("baud double not written");
	a_idle_set: assert property (s_sfr_wr ##0 i_sfr_wdata[0] |=> o_mcu_idle)
		else $error("idle not set by write");
	a_idle_ram_level: assert property (o_ram_low_power == o_mcu_idle)
		else $error("ram low power differs from idle");
	a_idle_suspends: assert property (o_mcu_idle |-> !o_wdt_running)
		else $error("watchdog counts while idle");
	a_idle_clear_cause: assert property ($fell(o_mcu_idle) |-> o_external_interrupt_one_irq || $past(o_external_interrupt_one_irq)
		|| $past(i_usb_rst && i_usb_rst_en))
		else $error("idle cleared without wake");
	a_wake_pulse_held: assert property (o_external_interrupt_one_irq |-> s_pin_held ##1 !o_external_interrupt_one_irq)
		else $error("wake recognised too early or too long");
	a_timeout_late: assert property (o_mcu_wdt_reset |-> run_cnt >= MIN_RUN)
		else $error("timeout before 32 ticks");
	a_timeout_pulse: assert property (o_mcu_wdt_reset |-> $past(o_wdt_running) ##1 !o_mcu_wdt_reset)
		else $error("timeout pulse wrong");
endmodule
bind fgw_watchdog_idle fgw_chk #(.TICK_CYCLES(TICK_CYCLES), .EXTERNAL_INTERRUPT_ONE_CYCLES(EXTERNAL_INTERRUPT_ONE_CYCLES)) chk (.*);

// ===== fgw_far_model.sv
/* Far-side model: frame detector and the wake pin of the core side.
   Assumes one bench process calls its tasks at a time. */
`timescale 1ns/1ps
module fgw_far_model (
	input wire logic i_clk_sys,
	output logic o_sof_det,
	output logic o_ext_external_interrupt_one_n
);
	initial begin
		o_sof_det = 1'b0;
		o_ext_external_interrupt_one_n = 1'b1;
	end
	task automatic sof_pulse();
		@(posedge i_clk_sys);
		#1 o_sof_det = 1'b1;
		@(posedge i_clk_sys);
		#1 o_sof_det = 1'b0;
	endtask
	// pin has a pull-up, so it returns high; short pulses are legal stimulus too
	task automatic wake_low(input int n);
		@(posedge i_clk_sys);
		#1 o_ext_external_interrupt_one_n = 1'b0;
		repeat (n) @(posedge i_clk_sys);
		#1 o_ext_external_interrupt_one_n = 1'b1;
	endtask
endmodule

// ===== fgw_watchdog_idle_bench.sv
/* Self-checking bench for fgw_watchdog_idle with the far-side model.
   Assumes short tick and wake counts to keep the run brief. */
`timescale 1ns/1ps
module fgw_watchdog_idle_bench;
	localparam int TICK = 4;
	localparam int WAKE = 8;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_xd_wdata = 8'h00;
	logic i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_xd_wr = 1'b0, i_xd_rd = 1'b0;
	logic [15:0] i_xd_addr = 16'h0000;
	logic i_usb_rst = 1'b0, i_usb_rst_en = 1'b0;
	logic i_sof_det, i_ext_external_interrupt_one_n, o_sfr_hit, o_xd_hit, o_mcu_wdt_reset, o_mcu_idle;
	logic o_ram_low_power, o_external_interrupt_one_irq, o_baud_double, o_wdt_running;
	logic [7:0] o_sfr_rdata, o_xd_rdata;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000004F;
	int errors = 0, total_checks = 0, resets = 0, irqs = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	fgw_far_model far (.i_clk_sys(i_clk_sys), .o_sof_det(i_sof_det), .o_ext_external_interrupt_one_n(i_ext_external_interrupt_one_n));
	fgw_watchdog_idle #(.TICK_CYCLES(TICK), .EXTERNAL_INTERRUPT_ONE_CYCLES(WAKE)) DUT (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH %0t saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one strobe cycle; x picks the xdata bus
	task automatic acc(input bit x, input bit wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		#1;
		i_sfr_addr = a[7:0];
		i_xd_addr = a;
		i_sfr_wdata = d;
		i_xd_wdata = d;
		i_sfr_wr = !x && wr;
		i_sfr_rd = !x && !wr;
		i_xd_wr = x && wr;
		i_xd_rd = x && !wr;
		@(posedge i_clk_sys);
		#1;
		{i_sfr_wr, i_sfr_rd, i_xd_wr, i_xd_rd} = 4'h0;
	endtask
	task automatic rd(input bit x, input logic [15:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		acc(x, 1'b0, a, 8'h00);
		@(posedge i_clk_sys);
	endtask
	task automatic usb_pulse(input logic en);
		@(posedge i_clk_sys);
		#1 i_usb_rst_en = en;
		i_usb_rst = 1'b1;
		@(posedge i_clk_sys);
		#1 i_usb_rst = 1'b0;
	endtask
	// reads are spaced by rd, so one pending answer at a time
	always @(posedge i_clk_sys) begin
		resets += (o_mcu_wdt_reset === 1'b1);
		irqs += (o_external_interrupt_one_irq === 1'b1);
		if ((i_sfr_rd && i_sfr_addr == 8'h87) || (i_xd_rd && i_xd_addr == 16'hFF93)) begin
			#2 check(o_sfr_rdata | o_xd_rdata, exp_q.pop_front());
		end
	end
	// about 1000 cycles expected; twenty times that
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done();
	end
	initial begin
		logic [7:0] v;
		int n;
		repeat (16) @(posedge i_clk_sys);
		#1 i_sys_rst = 1'b0;
		rd(0, 16'h0087, 8'h00);
		rd(1, 16'hFF93, 8'h00);
		for (int k = 0; k < 4; k++) begin
			v = 8'(xs());
			v[0] = 1'b0;
			acc(0, 1, 16'h0087, v);
			check(o_baud_double, v[7]);
			rd(0, 16'h0087, v & 8'h8C);
		end
		acc(0, 0, 16'h0088, 8'h00);
		check(o_sfr_rdata, 8'h00);
		$display("test power control done");
		acc(1, 1, 16'hFF93, 8'h80);
		repeat (200) @(posedge i_clk_sys);
		check(o_wdt_running, 1'b0);
		rd(1, 16'hFF93, 8'h80);
		far.sof_pulse();
		repeat (3) @(posedge i_clk_sys);
		#2 check(o_wdt_running, 1'b1);
		for (int k = 0; k < 3; k++) begin
			repeat (100) @(posedge i_clk_sys);
			acc(1, 1, 16'hFF93, 8'h81);
		end
		repeat (40) @(posedge i_clk_sys);
		acc(1, 1, 16'hFF93, 8'h80);
		check(8'(resets), 8'h00);
		n = 0;
		while (o_mcu_wdt_reset !== 1'b1 && n < 400) begin
			@(posedge i_clk_sys);
			#2 n++;
		end
		check(8'(n + 42 >= 32 * TICK && n + 42 <= 32 * TICK + 3), 8'h01);
		rd(1, 16'hFF93, 8'hC0);
		acc(1, 1, 16'hFF93, 8'h41);
		rd(1, 16'hFF93, 8'h80);
		$display("test watchdog done");
		acc(0, 1, 16'h0087, 8'h01);
		check(o_ram_low_power, 1'b1);
		acc(0, 1, 16'h0087, 8'h00);
		check(o_mcu_idle, 1'b1);
		repeat (300) @(posedge i_clk_sys);
		check(8'(resets), 8'h01);
		far.wake_low(WAKE - 3);
		repeat (10) @(posedge i_clk_sys);
		check(o_mcu_idle, 1'b1);
		far.wake_low(WAKE + 6);
		#2 check(8'(irqs), 8'h01);
		check(o_wdt_running, 1'b1);
		acc(1, 1, 16'hFF93, 8'h01);
		$display("test idle done");
		usb_pulse(1'b0);
		rd(1, 16'hFF93, 8'h80);
		usb_pulse(1'b1);
		rd(1, 16'hFF93, 8'h00);
		check(o_wdt_running, 1'b0);
		$display("test usb reset done");
		test_done();
	end
endmodule
